/* hw/xi_pin_det.sv */
// Pin sampling and request flag of one extra external interrupt
`timescale 1ns/1ps
`default_nettype none

module xi_pin_det (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Pin and mode
    input wire logic pin,
    input wire logic edge_sel,
    // Software write and service clear
    input wire logic wr_en,
    input wire logic wr_val,
    input wire logic svc_clr,
    // Flag
    output logic flag
);
    logic pin_q, pin_d;
    logic flag_q, flag_d;
    logic fall;

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        pin_d = pin;
        fall = pin_q & ~pin;
        flag_d = flag_q;
        if (!edge_sel) begin
            // Level mode: not latched, source must hold pin low
            flag_d = ~pin;
        end else if (fall) begin
            // Set beats a clear in the same cycle
            flag_d = 1'b1;
        end else if (wr_en) begin
            flag_d = wr_val;
        end else if (svc_clr) begin
            flag_d = 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_q <= 1'b1;
            flag_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;

endmodule : xi_pin_det

`default_nettype wire

/* hw/xi_top.sv */
// Extra external interrupts, seven-source arbiter and nibble port behind APB
// Function
// - Two extra external interrupts like standard ones
// - Control register at C0, bit-addressable
// - Bit address C2 sets first source enable
// - Priority bit set selects high level
// - Request raised only while enable set
// - Type bit: set falling edge, clear low level
// - Edge flag set on edge, cleared on service
// - Seven sources, two levels, vectors 03 to 3B
// - External zero vectors 03, polled first
// - External one 13 after timer zero 0B
// - First extra source vectors 33, position five
// - Second extra source vectors 3B, polled last
// - Nibble port at D8, four bits implemented
// - Port bits 3, 2 double as interrupt pins
// - Port latches reset to all ones
// - Control register resets to zero
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "xi_regs.svh"

module xi_top
    import xi_pkg::*;
#(
    parameter int NUM_EXT = 2,
    parameter int PORT_BITS = 4,
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Nibble port pins
    input wire logic [PORT_BITS-1:0] port_in,
    output logic [PORT_BITS-1:0] port_out,
    output logic [PORT_BITS-1:0] port_oe,
    // Interrupt sequencer
    input wire xi_std_irq_t std_irq,
    input wire xi_svc_t svc,
    output xi_irq_out_t irq
);

    // -----------------------------------------------------------------
    // Elaboration checks
    // -----------------------------------------------------------------
    if (NUM_EXT != 2) begin : g_bad_ext
        $error("xi_top: exactly two extra interrupts are supported");
    end
    if (PORT_BITS != 4) begin : g_bad_port
        $error("xi_top: nibble port must be four bits");
    end
    if (ADDR_W < 8) begin : g_bad_addr
        $error("xi_top: address must be at least eight bits");
    end

    // -----------------------------------------------------------------
    // Functions
    // -----------------------------------------------------------------
    // Lowest set position wins; used for both priority levels
    function automatic logic [2:0] xi_pick(input logic [6:0] m);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 6; i >= 0; i--) begin
            if (m[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : xi_pick

    function automatic logic [7:0] xi_vector(input logic [2:0] pos);
        logic [7:0] v;
        case (pos)
            3'h0: v = `XI_VEC_0;
            3'h1: v = `XI_VEC_1;
            3'h2: v = `XI_VEC_2;
            3'h3: v = `XI_VEC_3;
            3'h4: v = `XI_VEC_4;
            3'h5: v = `XI_VEC_5;
            3'h6: v = `XI_VEC_6;
            default: v = `XI_VEC_0;
        endcase
        return v;
    endfunction : xi_vector

    // Bit address hit on a byte-wide register with given base
    function automatic logic xi_bit_hit(input logic [7:0] ba, input logic [4:0] base);
        return ba[7:3] == base;
    endfunction : xi_bit_hit

    // -----------------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------------
    logic [7:0] ctrl_q, ctrl_d;
    logic [PORT_BITS-1:0] port_q, port_d;
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d;
    xi_irq_out_t irq_q, irq_d;
    logic [7:0] ctrl_view;
    logic [7:0] ctrl_new;
    logic [7:0] ctrl_wmask;
    logic [NUM_EXT-1:0] ext_flag;
    logic [NUM_EXT-1:0] ext_pin;
    logic [6:0] all_req;
    logic [6:0] all_high;
    logic setup_ph, acc_wr;
    logic [7:0] wr_byte;
    logic [7:0] bit_addr;
    logic bit_val;
    logic hit_ctrl, hit_port, hit_bitop;

    // -----------------------------------------------------------------
    // APB decode
    // -----------------------------------------------------------------
    assign setup_ph = psel & ~penable;
    // Write lands on the access edge; slave never stalls
    assign acc_wr = psel & penable & pwrite & pstrb[0];
    assign pready = 1'b1;
    assign hit_ctrl = paddr[7:0] == `XI_OFS_CTRL;
    assign hit_port = paddr[7:0] == `XI_OFS_PORT;
    assign hit_bitop = paddr[7:0] == `XI_OFS_BITOP;
    assign wr_byte = pwdata[7:0];
    assign bit_addr = pwdata[`XI_BITOP_ADDR_HI:0];
    assign bit_val = pwdata[`XI_BITOP_VAL];

    // -----------------------------------------------------------------
    // Extra interrupt sources on port bits 2 and 3
    // -----------------------------------------------------------------
    // Pin read comes straight from the pad, as on the other ports
    assign ext_pin = port_in[PORT_BITS-1:PORT_BITS-NUM_EXT];

    for (genvar s = 0; s < NUM_EXT; s++) begin : g_src
        localparam int B = s * `XI_SRC_STRIDE;
        logic svc_hit;
        assign svc_hit = svc.ack && svc.src == 3'(`XI_POS_EXT_A + s);
        xi_pin_det u_det (
            .core_clk(core_clk),
            .rst(rst),
            .pin(ext_pin[s]),
            .edge_sel(ctrl_q[B + `XI_F_EDGE]),
            .wr_en(ctrl_wmask[B + `XI_F_FLAG] & ctrl_q[B + `XI_F_EDGE]),
            .wr_val(ctrl_new[B + `XI_F_FLAG]),
            .svc_clr(svc_hit),
            .flag(ext_flag[s])
        );
        assign all_req[5 + s] = ext_flag[s] & ctrl_q[B + `XI_F_EN];
        assign all_high[5 + s] = ctrl_q[B + `XI_F_PRIO];
    end

    assign all_req[4:0] = std_irq.req;
    assign all_high[4:0] = std_irq.high;

    // -----------------------------------------------------------------
    // Control register view and write merge
    // -----------------------------------------------------------------
    always_comb begin
        ctrl_view = ctrl_q;
        for (int s = 0; s < NUM_EXT; s++) begin
            ctrl_view[s * `XI_SRC_STRIDE + `XI_F_FLAG] = ext_flag[s];
        end
        ctrl_new = ctrl_view;
        ctrl_wmask = 8'h00;
        if (acc_wr && hit_ctrl) begin
            ctrl_new = wr_byte;
            ctrl_wmask = 8'hFF;
        end else if (acc_wr && hit_bitop && xi_bit_hit(bit_addr, `XI_BA_CTRL)) begin
            // Single-bit set or clear, e.g. bit address C2 sets enable A
            ctrl_new[bit_addr[2:0]] = bit_val;
            ctrl_wmask[bit_addr[2:0]] = 1'b1;
        end
        ctrl_d = ctrl_new;
    end

    // -----------------------------------------------------------------
    // Nibble port latch
    // -----------------------------------------------------------------
    always_comb begin
        port_d = port_q;
        if (acc_wr && hit_port) begin
            port_d = wr_byte[PORT_BITS-1:0];
        end else if (acc_wr && hit_bitop && xi_bit_hit(bit_addr, `XI_BA_PORT)
                     && bit_addr[2:0] < 3'(PORT_BITS)) begin
            port_d[bit_addr[1:0]] = bit_val;
        end
    end

    // Quasi-bidirectional: a latch of one leaves the pin to the pull-up
    assign port_out = port_q;
    assign port_oe = ~port_q;

    // -----------------------------------------------------------------
    // Read data, captured in setup so it stands through access
    // -----------------------------------------------------------------
    always_comb begin
        rdata_d = rdata_q;
        err_d = 1'b0;
        if (setup_ph) begin
            rdata_d = `XI_ZERO32;
            err_d = 1'b0;
            if (hit_ctrl) begin
                rdata_d[7:0] = ctrl_view;
            end else if (hit_port) begin
                // Port reads the pins, not the latch, like port one
                rdata_d[PORT_BITS-1:0] = port_in;
            end else if (!hit_bitop) begin
                err_d = 1'b1;
            end
        end else if (psel && penable) begin
            err_d = err_q;
        end
    end

    assign prdata = rdata_q;
    assign pslverr = psel & penable & err_q;

    // -----------------------------------------------------------------
    // Arbitration towards the sequencer
    // -----------------------------------------------------------------
    always_comb begin
        logic [6:0] hi_m;
        logic [6:0] lo_m;
        hi_m = all_req & all_high;
        lo_m = all_req & ~all_high;
        irq_d = '0;
        if (|hi_m) begin
            irq_d.valid = 1'b1;
            irq_d.high = 1'b1;
            irq_d.src = xi_pick(hi_m);
        end else if (|lo_m) begin
            irq_d.valid = 1'b1;
            irq_d.high = 1'b0;
            irq_d.src = xi_pick(lo_m);
        end
        irq_d.vector = irq_d.valid ? xi_vector(irq_d.src) : 8'h00;
    end

    assign irq = irq_q;

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_q <= `XI_CTRL_RST;
            port_q <= `XI_PORT_RST;
            rdata_q <= `XI_ZERO32;
            err_q <= 1'b0;
            irq_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            port_q <= port_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
            irq_q <= irq_d;
        end
    end

endmodule : xi_top

`default_nettype wire

/* include/xi_pkg.sv */
// Types shared by the extra interrupt block and its surroundings
package xi_pkg;

    // -----------------------------------------------------------------
    // Standard sources presented by the core (positions 0..4)
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [4:0] req;
        logic [4:0] high;
    } xi_std_irq_t;

    // -----------------------------------------------------------------
    // Request towards the interrupt sequencer
    // -----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic high;
        logic [2:0] src;
        logic [7:0] vector;
    } xi_irq_out_t;

    // -----------------------------------------------------------------
    // Service acknowledge from the sequencer
    // -----------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [2:0] src;
    } xi_svc_t;

endpackage : xi_pkg

/* include/xi_regs.svh */
// Register offsets, field positions, reset values and vectors of the extra interrupt block
`ifndef XI_REGS_SVH
`define XI_REGS_SVH

// -----------------------------------------------------------------
// Byte offsets on the register bus
// -----------------------------------------------------------------
`define XI_OFS_CTRL 8'hC0
`define XI_OFS_PORT 8'hD8
`define XI_OFS_BITOP 8'h10

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define XI_CTRL_RST 8'h00
`define XI_PORT_RST 4'hF
`define XI_ZERO32 32'h0000_0000

// -----------------------------------------------------------------
// Control fields, per source at base = source * stride
// -----------------------------------------------------------------
`define XI_SRC_STRIDE 4
`define XI_F_EDGE 0
`define XI_F_FLAG 1
`define XI_F_EN 2
`define XI_F_PRIO 3

// -----------------------------------------------------------------
// Bit-address operation word and bit-address bases
// -----------------------------------------------------------------
`define XI_BITOP_ADDR_HI 7
`define XI_BITOP_VAL 8
`define XI_BA_CTRL 5'h18
`define XI_BA_PORT 5'h1B

// -----------------------------------------------------------------
// Vector table, one per polling position
// -----------------------------------------------------------------
`define XI_VEC_0 8'h03
`define XI_VEC_1 8'h0B
`define XI_VEC_2 8'h13
`define XI_VEC_3 8'h1B
`define XI_VEC_4 8'h23
`define XI_VEC_5 8'h33
`define XI_VEC_6 8'h3B
`define XI_POS_EXT_A 3'h5

`endif

/* test/tb_xi_top.sv */
// Self-checking bench of the extra interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_xi_top
    import xi_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [3:0] pull_lo = 4'h0;
    logic ack_en = 1'b0;
    xi_std_irq_t std_irq = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er;
    logic [3:0] port_in, port_out, port_oe;
    xi_svc_t svc;
    xi_irq_out_t irq;
    int n_mismatch = 0;
    int n_checks = 0;
    logic [7:0] vecs [5] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23};

    always #12.5 core_clk = ~core_clk;

    xi_top i_xi_top (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .port_in, .port_out, .port_oe, .std_irq, .svc, .irq);
    xi_far_model i_xi_far_model (.core_clk, .rst, .port_oe, .pull_lo, .port_in, .irq, .ack_en, .svc);

    // ---------------------------------------------------------------
    // Reporting and bus helpers
    // ---------------------------------------------------------------
    task close_out;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out
    task give_up;
        n_mismatch++;
        $display("FAIL %0t wait ran out", $time);
        close_out();
    endtask : give_up
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task chk_irq(input logic v, input logic h, input logic [2:0] s, input logic [7:0] vec);
        chk({19'h0, irq.valid, irq.high, irq.src, irq.vector}, {19'h0, v, h, s, vec});
    endtask : chk_irq
    // Holds the request until pready is seen at an edge, then releases
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge core_clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) give_up();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task wait_irq(input logic v);
        int i;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (irq.valid === v) break;
        end
        if (i == 20) give_up();
    endtask : wait_irq

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task t_regs;
        chk(port_out, 4'hF);
        chk(port_oe, 4'h0);
        apb(1'b0, 8'hC0, 0);
        chk(rd, 32'h0);
        apb(1'b1, 8'hD8, 32'h0A);
        chk(port_out, 4'hA);
        chk(port_oe, 4'h5);
        apb(1'b0, 8'hD8, 0);
        chk(rd, 32'h0A);
        apb(1'b1, 8'hD8, 32'h0F);
        apb(1'b1, 8'h10, 32'h0D9);
        chk(port_out, 4'hD);
        apb(1'b1, 8'h10, 32'h1C2);
        apb(1'b0, 8'hC0, 0);
        chk(rd, 32'h04);
        apb(1'b1, 8'h10, 32'h0C2);
        apb(1'b0, 8'h44, 0);
        chk({rd[30:0], er}, 32'h1);
        $display("register test done");
    endtask : t_regs
    task t_edge;
        apb(1'b1, 8'hC0, 32'h05);
        pull_lo[2] <= 1'b1;
        wait_irq(1'b1);
        chk_irq(1'b1, 1'b0, 3'h5, 8'h33);
        apb(1'b0, 8'hC0, 0);
        chk(rd, 32'h07);
        ack_en <= 1'b1;
        wait_irq(1'b0);
        ack_en <= 1'b0;
        apb(1'b0, 8'hC0, 0);
        chk(rd, 32'h05);
        pull_lo[2] <= 1'b0;
        $display("edge test done");
    endtask : t_edge
    task t_level;
        apb(1'b1, 8'hC0, 32'hC0);
        pull_lo[3] <= 1'b1;
        wait_irq(1'b1);
        chk_irq(1'b1, 1'b1, 3'h6, 8'h3B);
        apb(1'b0, 8'hC0, 0);
        chk(rd, 32'hE0);
        pull_lo[3] <= 1'b0;
        wait_irq(1'b0);
        $display("level test done");
    endtask : t_level
    task t_mask;
        apb(1'b1, 8'hC0, 32'h01);
        pull_lo[2] <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(irq.valid, 1'b0);
        apb(1'b0, 8'hC0, 0);
        chk(rd, 32'h03);
        apb(1'b1, 8'hC0, 0);
        pull_lo[2] <= 1'b0;
        $display("mask test done");
    endtask : t_mask
    task t_order;
        for (int k = 0; k < 5; k++) begin
            std_irq <= '{req: 5'h1F << k, high: 5'h00};
            repeat (2) @(posedge core_clk);
            chk_irq(1'b1, 1'b0, 3'(k), vecs[k]);
        end
        std_irq <= '{req: 5'h1F, high: 5'h10};
        repeat (2) @(posedge core_clk);
        chk_irq(1'b1, 1'b1, 3'h4, 8'h23);
        std_irq <= '{req: 5'h1F, high: 5'h11};
        repeat (2) @(posedge core_clk);
        chk_irq(1'b1, 1'b1, 3'h0, 8'h03);
        std_irq <= '0;
        $display("order test done");
    endtask : t_order

    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_regs();
        t_edge();
        t_level();
        t_mask();
        t_order();
        close_out();
    end
endmodule : tb_xi_top
`default_nettype wire

/* test/xi_far_model.sv */
// Far side: pulled-up pins with outside pull-downs, and a service sequencer
`timescale 1ns/1ps
`default_nettype none
module xi_far_model
    import xi_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Pins
    input wire logic [3:0] port_oe,
    input wire logic [3:0] pull_lo,
    output logic [3:0] port_in,
    // Sequencer
    input wire xi_irq_out_t irq,
    input wire logic ack_en,
    output xi_svc_t svc
);
    logic served_q;
    // Pull-up holds pins high unless some party pulls low
    assign port_in = ~(port_oe | pull_lo);
    // One service pulse per request, so a held level is not acked twice
    always_ff @(posedge core_clk) begin
        if (rst) begin
            served_q <= 1'b0;
            svc <= '0;
        end else begin
            svc.ack <= ack_en && irq.valid && !served_q && !svc.ack;
            svc.src <= irq.src;
            served_q <= irq.valid && (served_q || svc.ack);
        end
    end
endmodule : xi_far_model
`default_nettype wire

/* test/xi_top_properties.sv */
// Port-level checks of the extra interrupt block
`timescale 1ns/1ps
`default_nettype none
module xi_top_properties
    import xi_pkg::*;
#(
    parameter int PORT_BITS = 4,
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pslverr,
    // Port and interrupts
    input wire logic [PORT_BITS-1:0] port_out,
    input wire xi_std_irq_t std_irq,
    input wire xi_irq_out_t irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic mapped;
    logic std0_hi;
    assign mapped = (paddr == 8'hC0) || (paddr == 8'hD8) || (paddr == 8'h10);
    assign std0_hi = std_irq.req[0] & std_irq.high[0];
    // Port write is one access phase, latch follows the next edge
    sequence port_wr_s;
        psel && penable && pwrite && pstrb[0] && (paddr == 8'hD8);
    endsequence
    unmapped_err_a: assert property (psel && penable && !mapped |-> pslverr)
        else $error("Unmapped access without error");
    port_write_a: assert property (port_wr_s |=> port_out == $past(pwdata[3:0]))
        else $error("Port latch did not take write");
    reset_val_a: assert property ($past(rst) |-> port_out == 4'hF && !irq.valid)
        else $error("Wrong state after reset");
    quiet_vec_a: assert property (!irq.valid |-> irq.vector == 8'h00)
        else $error("Vector without request");
    vec_first_a: assert property (irq.valid && irq.src == 3'h5 |-> irq.vector == 8'h33)
        else $error("Wrong vector for first extra source");
    vec_second_a: assert property (irq.valid && irq.src == 3'h6 |-> irq.vector == 8'h3B)
        else $error("Wrong vector for second extra source");
    std_first_a: assert property ($past(std0_hi) |-> irq.valid && irq.src == 3'h0 && irq.vector == 8'h03)
        else $error("Source zero not chosen first");
    high_first_a: assert property (irq.valid && !irq.high |-> $past(std_irq.req & std_irq.high) == 5'h00)
        else $error("Low level chosen over high");
endmodule : xi_top_properties
bind xi_top xi_top_properties #(.PORT_BITS(PORT_BITS), .ADDR_W(ADDR_W)) i_xi_top_properties (.core_clk, .rst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pslverr, .port_out, .std_irq, .irq);
`default_nettype wire
